/* shared/tdmsw_pkg.sv */
package tdmsw_pkg;

   // Widths of the host bus and of the memory indices
   localparam int ADDR_W  = 19;
   localparam int DATA_W  = 32;
   localparam int GRP_W   = 5;
   localparam int OFF_W   = 10;
   localparam int IDX_W   = 15;
   localparam int BYTE_W  = 8;
   localparam int BE_W    = 4;
   localparam int CONN_WORDS = 32768;
   localparam int DATA_BYTES = 32768;

   // Global data rate codes; 8 Mbps is the reset rate
   localparam logic [1:0] RATE_8M  = 2'h0;
   localparam logic [1:0] RATE_16M = 2'h1;
   localparam logic [1:0] RATE_32M = 2'h2;
   localparam logic [1:0] RATE_65M = 2'h3;

   // Space selection taken from the top address bits
   localparam logic [1:0] CONN_SEL  = 2'h0;
   localparam logic [3:0] ALIAS_SEL = 4'h4;
   localparam logic [3:0] DATA_SEL  = 4'h5;

   // Switching memory word fields
   localparam int FN_HI   = 31;
   localparam int FN_LO   = 29;
   localparam int GRP_HI  = 14;
   localparam int GRP_LO  = 10;
   localparam int MESSAGE_HI = 7;

   // Per-channel function codes
   localparam logic [2:0] FN_TRISTATE = 3'h0;
   localparam logic [2:0] FN_HIGH     = 3'h1;
   localparam logic [2:0] FN_MESSAGE  = 3'h2;
   localparam logic [2:0] FN_VARDELAY = 3'h3;
   localparam logic [2:0] FN_CONDELAY = 3'h4;

   // Reset and fill values
   localparam logic [31:0] WORD_ZERO  = 32'h00000000;
   localparam logic [7:0]  BYTE_HIGH  = 8'hFF;
   localparam logic [7:0]  BYTE_ZERO  = 8'h00;
   localparam logic [1:0]  LANE_LAST  = 2'h3;

   typedef enum logic [1:0] {
      SP_NONE, SP_CONN, SP_ALIAS, SP_DATA
   } tdmsw_space_t;

   typedef enum logic [1:0] {
      ST_IDLE   = 2'b00,
      ST_READ   = 2'b01,
      ST_MODIFY = 2'b11,
      ST_FINISH = 2'b10
   } tdmsw_state_t;

   typedef enum logic [1:0] {
      OUT_TRI, OUT_HIGH, OUT_MESSAGE, OUT_CONN
   } tdmsw_drive_t;

   // Offset of a timeslot within a group, in entries, for the given rate
   function automatic logic [9:0] streamOffset(
      input logic [1:0] rate,
      input logic [1:0] stream,
      input logic [9:0] slot);
      unique case (rate)
         RATE_65M: streamOffset = slot;
         RATE_32M: streamOffset = {stream[0], slot[8:0]};
         RATE_16M: streamOffset = {stream, slot[7:0]};
         RATE_8M:  streamOffset = {1'b0, stream, slot[6:0]};
      endcase
   endfunction : streamOffset

endpackage : tdmsw_pkg

/* hdl/tdmsw_addr_decode.sv */
`timescale 1ns/1ns
module tdmsw_addr_decode (
   input  wire logic [18:0]          addr,
   input  wire logic                 isWrite,
   input  wire logic [1:0]           rate,
   output tdmsw_pkg::tdmsw_space_t   space,
   output logic [14:0]               index,
   output logic                      accessError
);

   // Space, entry index and error for one host address
   always_comb begin
      space       = tdmsw_pkg::SP_NONE;
      index       = 15'h0000;
      accessError = 1'b1;
      if (addr[18:17] == tdmsw_pkg::CONN_SEL) begin
         space       = tdmsw_pkg::SP_CONN;
         index       = {addr[16:12], addr[11:2]};
         accessError = (rate == tdmsw_pkg::RATE_8M) && addr[11];
      end else if (addr[18:15] == tdmsw_pkg::ALIAS_SEL) begin
         space       = tdmsw_pkg::SP_ALIAS;
         index       = {addr[14:12], addr[11:0]} & 15'h7FFC;
         accessError = (rate == tdmsw_pkg::RATE_8M) && addr[9];
      end else if (addr[18:15] == tdmsw_pkg::DATA_SEL) begin
         space       = tdmsw_pkg::SP_DATA;
         index       = {addr[14:12], addr[11:0]} & 15'h7FFC;
         // Writes refused; 8 Mbps upper half unused
         accessError = isWrite ||
                       ((rate == tdmsw_pkg::RATE_8M) && addr[9]);
      end
   end

endmodule : tdmsw_addr_decode

/* hdl/tdmsw_slot_engine.sv */
`timescale 1ns/1ns
module tdmsw_slot_engine (
   input  wire logic [31:0]          word,
   input  wire logic [1:0]           rate,
   output tdmsw_pkg::tdmsw_drive_t   drive,
   output logic [14:0]               srcIndex,
   output logic [7:0]                messageByte
);

   logic [1:0] srcStream;
   logic [9:0] srcChan;

   // Output behaviour from the per-channel function field
   always_comb begin
      unique case (word[tdmsw_pkg::FN_HI:tdmsw_pkg::FN_LO])
         tdmsw_pkg::FN_HIGH:     drive = tdmsw_pkg::OUT_HIGH;
         tdmsw_pkg::FN_MESSAGE:  drive = tdmsw_pkg::OUT_MESSAGE;
         tdmsw_pkg::FN_VARDELAY: drive = tdmsw_pkg::OUT_CONN;
         tdmsw_pkg::FN_CONDELAY: drive = tdmsw_pkg::OUT_CONN;
         default:                drive = tdmsw_pkg::OUT_TRI;
      endcase
   end

   // Source stream and channel split by rate
   always_comb begin
      unique case (rate)
         tdmsw_pkg::RATE_65M: begin
            srcStream = 2'h0;
            srcChan   = word[9:0];
         end
         tdmsw_pkg::RATE_32M: begin
            srcStream = {1'b0, word[0]};
            srcChan   = {1'b0, word[9:1]};
         end
         tdmsw_pkg::RATE_16M: begin
            srcStream = word[1:0];
            srcChan   = {2'h0, word[9:2]};
         end
         tdmsw_pkg::RATE_8M: begin
            srcStream = word[1:0];
            srcChan   = {3'h0, word[9:3]};
         end
      endcase
   end

   // Source group plus stream offset gives the data memory entry
   assign srcIndex = {word[tdmsw_pkg::GRP_HI:tdmsw_pkg::GRP_LO],
                      tdmsw_pkg::streamOffset(rate, srcStream, srcChan)};
   // Message byte; bits 9-8 unused
   assign messageByte = word[tdmsw_pkg::MESSAGE_HI:0];

endmodule : tdmsw_slot_engine

/* hdl/tdmsw_access_map.sv */
`timescale 1ns/1ns
module tdmsw_access_map (
   input  wire logic        sys_clk,
   input  wire logic        rst,
   input  wire logic [1:0]  rateSel,
   input  wire logic        hostSel,
   input  wire logic        hostWrite,
   input  wire logic [18:0] hostAddr,
   input  wire logic [3:0]  hostByteEn,
   input  wire logic [31:0] hostWrData,
   output logic      [31:0] hostRdData,
   output logic             hostDone,
   output logic             busErrorN,
   input  wire logic        inValid,
   input  wire logic [4:0]  inGroup,
   input  wire logic [1:0]  inStream,
   input  wire logic [9:0]  inSlot,
   input  wire logic [7:0]  inByte,
   input  wire logic        slotReq,
   input  wire logic [4:0]  outGroup,
   input  wire logic [1:0]  outStream,
   input  wire logic [9:0]  outSlot,
   output logic             slotValid,
   output logic             slotOe,
   output logic      [7:0]  slotByte
);

   // Memories
   logic [31:0] connMem [tdmsw_pkg::CONN_WORDS];
   logic [7:0]  dataMem [tdmsw_pkg::DATA_BYTES];

   // Host sequencer state
   tdmsw_pkg::tdmsw_state_t state_r, state_nxt;
   tdmsw_pkg::tdmsw_space_t space_r, space_nxt;
   logic        write_r, write_nxt;
   logic [14:0] base_r, base_nxt;
   logic [1:0]  lane_r, lane_nxt;
   logic [31:0] wrData_r, wrData_nxt;
   logic [3:0]  byteEn_r, byteEn_nxt;
   logic [31:0] rdData_r, rdData_nxt;
   logic        done_r, done_nxt;
   logic        errN_r, errN_nxt;

   // Slot pipeline state
   logic                    req1_r, req1_nxt;
   logic                    req2_r, req2_nxt;
   tdmsw_pkg::tdmsw_drive_t drive2_r, drive2_nxt;
   logic [7:0]              message2_r, message2_nxt;
   logic                    slotValid_r, slotValid_nxt;
   logic                    slotOe_r, slotOe_nxt;
   logic [7:0]              slotByte_r, slotByte_nxt;

   // Decoder and engine results, memory ports
   tdmsw_pkg::tdmsw_space_t decSpace;
   tdmsw_pkg::tdmsw_drive_t engDrive;
   logic [14:0] decIndex;
   logic        decError;
   logic [14:0] portAIdx;
   logic [14:0] slotIdx;
   logic [14:0] srcIdx;
   logic [14:0] inIdx;
   logic [7:0]  engMessage;
   logic [31:0] connQA;
   logic [31:0] connQB;
   logic [7:0]  dataQA;
   logic [7:0]  dataQB;
   logic        connWe;
   logic [31:0] connWrWord;
   logic        lastLane;

   tdmsw_addr_decode u_decode (
      .addr        (hostAddr),
      .isWrite     (hostWrite),
      .rate        (rateSel),
      .space       (decSpace),
      .index       (decIndex),
      .accessError (decError)
   );

   tdmsw_slot_engine u_engine (
      .word     (connQB),
      .rate     (rateSel),
      .drive    (engDrive),
      .srcIndex (srcIdx),
      .messageByte (engMessage)
   );

   // Byte of the write data belonging to one alias lane, big-endian
   function automatic logic [7:0] laneByte(
      input logic [31:0] data,
      input logic [1:0]  lane);
      unique case (lane)
         2'h0: laneByte = data[31:24];
         2'h1: laneByte = data[23:16];
         2'h2: laneByte = data[15:8];
         2'h3: laneByte = data[7:0];
      endcase
   endfunction : laneByte

   // Entry addresses for host, output lookup and input capture
   assign portAIdx = base_r | {13'h0000, lane_r};
   assign slotIdx  = {outGroup,
                      tdmsw_pkg::streamOffset(rateSel, outStream, outSlot)};
   assign inIdx    = {inGroup,
                      tdmsw_pkg::streamOffset(rateSel, inStream, inSlot)};
   assign lastLane = (space_r == tdmsw_pkg::SP_CONN) ||
                     (lane_r == tdmsw_pkg::LANE_LAST);

   // Switching memory write word: byte-enable merge or low-byte update
   always_comb begin
      connWrWord = connQA;
      connWe     = 1'b0;
      if (state_r == tdmsw_pkg::ST_MODIFY && write_r) begin
         if (space_r == tdmsw_pkg::SP_CONN) begin
            connWe = 1'b1;
            for (int k = 0; k < tdmsw_pkg::BE_W; k++) begin
               if (byteEn_r[k]) begin
                  connWrWord[8*k +: 8] = wrData_r[8*k +: 8];
               end
            end
         end else if (space_r == tdmsw_pkg::SP_ALIAS) begin
            connWe = 1'b1;
            if (byteEn_r[2'h3 - lane_r]) begin
               connWrWord[7:0] = laneByte(wrData_r, lane_r);
            end
         end
      end
   end

   // Switching memory: host port and output lookup port
   always_ff @(posedge sys_clk) begin
      if (connWe) begin
         connMem[portAIdx] <= connWrWord;
      end
      connQA <= connMem[portAIdx];
      connQB <= connMem[slotIdx];
   end

   // Data memory: input capture and two read ports
   always_ff @(posedge sys_clk) begin
      if (inValid) begin
         dataMem[inIdx] <= inByte;
      end
      dataQA <= dataMem[portAIdx];
      dataQB <= dataMem[srcIdx];
   end

   // Host sequencer next values
   always_comb begin
      state_nxt  = state_r;
      space_nxt  = space_r;
      write_nxt  = write_r;
      base_nxt   = base_r;
      lane_nxt   = lane_r;
      wrData_nxt = wrData_r;
      byteEn_nxt = byteEn_r;
      rdData_nxt = rdData_r;
      done_nxt   = 1'b0;
      errN_nxt   = 1'b1;
      unique case (state_r)
         tdmsw_pkg::ST_IDLE: begin
            if (hostSel) begin
               space_nxt  = decSpace;
               write_nxt  = hostWrite;
               base_nxt   = decIndex;
               lane_nxt   = 2'h0;
               wrData_nxt = hostWrData;
               byteEn_nxt = hostByteEn;
               rdData_nxt = tdmsw_pkg::WORD_ZERO;
               if (decError) begin
                  state_nxt = tdmsw_pkg::ST_FINISH;
                  errN_nxt  = 1'b0;
               end else begin
                  state_nxt = tdmsw_pkg::ST_READ;
               end
            end
         end
         tdmsw_pkg::ST_READ: begin
            state_nxt = tdmsw_pkg::ST_MODIFY;
         end
         tdmsw_pkg::ST_MODIFY: begin
            // Read data placed by lane; lowest channel on the top byte
            unique case (space_r)
               tdmsw_pkg::SP_CONN: rdData_nxt = connQA;
               tdmsw_pkg::SP_ALIAS: begin
                  for (int k = 0; k < tdmsw_pkg::BE_W; k++) begin
                     if (lane_r == k[1:0]) begin
                        rdData_nxt[31-8*k -: 8] = connQA[7:0];
                     end
                  end
               end
               tdmsw_pkg::SP_DATA: begin
                  for (int k = 0; k < tdmsw_pkg::BE_W; k++) begin
                     if (lane_r == k[1:0]) begin
                        rdData_nxt[31-8*k -: 8] = dataQA;
                     end
                  end
               end
               tdmsw_pkg::SP_NONE: rdData_nxt = rdData_r;
            endcase
            if (lastLane) begin
               state_nxt = tdmsw_pkg::ST_FINISH;
            end else begin
               lane_nxt  = lane_r + 2'h1;
               state_nxt = tdmsw_pkg::ST_READ;
            end
         end
         tdmsw_pkg::ST_FINISH: begin
            state_nxt = tdmsw_pkg::ST_IDLE;
         end
      endcase
      if (state_nxt == tdmsw_pkg::ST_FINISH) begin
         done_nxt = 1'b1;
      end
   end

   // Host sequencer registers
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         state_r  <= tdmsw_pkg::ST_IDLE;
         space_r  <= tdmsw_pkg::SP_NONE;
         write_r  <= 1'b0;
         base_r   <= 15'h0000;
         lane_r   <= 2'h0;
         wrData_r <= tdmsw_pkg::WORD_ZERO;
         byteEn_r <= 4'h0;
         rdData_r <= tdmsw_pkg::WORD_ZERO;
         done_r   <= 1'b0;
         errN_r   <= 1'b1;
      end else begin
         state_r  <= state_nxt;
         space_r  <= space_nxt;
         write_r  <= write_nxt;
         base_r   <= base_nxt;
         lane_r   <= lane_nxt;
         wrData_r <= wrData_nxt;
         byteEn_r <= byteEn_nxt;
         rdData_r <= rdData_nxt;
         done_r   <= done_nxt;
         errN_r   <= errN_nxt;
      end
   end

   // Slot pipeline next values
   always_comb begin
      req1_nxt      = slotReq;
      req2_nxt      = req1_r;
      drive2_nxt    = engDrive;
      message2_nxt  = engMessage;
      slotValid_nxt = req2_r;
      slotOe_nxt    = slotOe_r;
      slotByte_nxt  = slotByte_r;
      if (req2_r) begin
         unique case (drive2_r)
            tdmsw_pkg::OUT_TRI: begin
               slotOe_nxt   = 1'b0;
               slotByte_nxt = tdmsw_pkg::BYTE_ZERO;
            end
            tdmsw_pkg::OUT_HIGH: begin
               slotOe_nxt   = 1'b1;
               slotByte_nxt = tdmsw_pkg::BYTE_HIGH;
            end
            tdmsw_pkg::OUT_MESSAGE: begin
               slotOe_nxt   = 1'b1;
               slotByte_nxt = message2_r;
            end
            tdmsw_pkg::OUT_CONN: begin
               slotOe_nxt   = 1'b1;
               slotByte_nxt = dataQB;
            end
         endcase
      end
   end

   // Slot pipeline registers
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         req1_r      <= 1'b0;
         req2_r      <= 1'b0;
         drive2_r    <= tdmsw_pkg::OUT_TRI;
         message2_r  <= tdmsw_pkg::BYTE_ZERO;
         slotValid_r <= 1'b0;
         slotOe_r    <= 1'b0;
         slotByte_r  <= tdmsw_pkg::BYTE_ZERO;
      end else begin
         req1_r      <= req1_nxt;
         req2_r      <= req2_nxt;
         drive2_r    <= drive2_nxt;
         message2_r  <= message2_nxt;
         slotValid_r <= slotValid_nxt;
         slotOe_r    <= slotOe_nxt;
         slotByte_r  <= slotByte_nxt;
      end
   end

   assign hostRdData = rdData_r;
   assign hostDone   = done_r;
   assign busErrorN  = errN_r;
   assign slotValid  = slotValid_r;
   assign slotOe     = slotOe_r;
   assign slotByte   = slotByte_r;

endmodule : tdmsw_access_map

/* verification/tdmsw_access_checker.sv */
`timescale 1ns/1ns
module tdmsw_access_checker (
   input wire logic        sys_clk,
   input wire logic        rst,
   input wire logic [1:0]  rateSel,
   input wire logic        hostSel,
   input wire logic        hostWrite,
   input wire logic [18:0] hostAddr,
   input wire logic [31:0] hostRdData,
   input wire logic        hostDone,
   input wire logic        busErrorN,
   input wire logic        slotReq,
   input wire logic        slotValid,
   input wire logic        slotOe,
   input wire logic [7:0]  slotByte
);
   logic busyR, busyNxt, take, r8, cSp, aSp, dSp, bad;

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);

   // Access in flight from the take edge through the done cycle
   always_comb busyNxt = busyR ? !hostDone : hostSel;
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         busyR <= 1'b0;
      end else begin
         busyR <= busyNxt;
      end
   end

   // Space and legality of the request being taken
   assign take = !busyR && hostSel;
   assign r8   = rateSel == tdmsw_pkg::RATE_8M;
   assign cSp  = hostAddr[18:17] == tdmsw_pkg::CONN_SEL;
   assign aSp  = hostAddr[18:15] == tdmsw_pkg::ALIAS_SEL;
   assign dSp  = hostAddr[18:15] == tdmsw_pkg::DATA_SEL;
   assign bad  = hostAddr >= 19'h30000 || (dSp && hostWrite)
               || (r8 && cSp && hostAddr[11])
               || (r8 && (aSp || dSp) && hostAddr[9]);

   chk_conn_timing: assert property (
      take && cSp && !bad |=> !hostDone [*2] ##1 (hostDone && busErrorN))
      else $error("switching word access not done in 3 cycles");
   chk_wide_timing: assert property (
      take && (aSp || dSp) && !bad |=> !hostDone [*8] ##1
      (hostDone && busErrorN))
      else $error("alias or data access not done in 9 cycles");
   chk_err_reply: assert property (
      take && bad |=> hostDone && !busErrorN)
      else $error("illegal access not ended by bus error");
   chk_err_zero: assert property (
      !busErrorN |-> hostDone && hostRdData == tdmsw_pkg::WORD_ZERO)
      else $error("bus error without done or with data");
   chk_done_single: assert property (
      hostDone |=> !hostDone)
      else $error("done longer than one cycle");
   chk_done_cause: assert property (
      hostDone |-> busyR)
      else $error("done without a taken access");
   chk_slot_timing: assert property (
      slotReq |-> ##3 slotValid)
      else $error("slot lookup not answered after 3 cycles");
   chk_valid_cause: assert property (
      slotValid |-> $past(slotReq, 3))
      else $error("slot answer without request");
   chk_out_hold: assert property (
      !slotValid |-> $stable(slotOe) && $stable(slotByte))
      else $error("slot outputs moved without answer");
   chk_tri_byte: assert property (
      slotValid && !slotOe |-> slotByte == tdmsw_pkg::BYTE_ZERO)
      else $error("tri-state slot with nonzero byte");

   cover property (take && aSp && hostWrite);
   cover property (take && bad);
   cover property (slotValid && slotOe);
endmodule : tdmsw_access_checker

bind tdmsw_access_map tdmsw_access_checker tdmsw_access_checker_inst (
   .sys_clk(sys_clk), .rst(rst), .rateSel(rateSel), .hostSel(hostSel),
   .hostWrite(hostWrite), .hostAddr(hostAddr), .hostRdData(hostRdData),
   .hostDone(hostDone), .busErrorN(busErrorN), .slotReq(slotReq),
   .slotValid(slotValid), .slotOe(slotOe), .slotByte(slotByte));

/* verification/tdmsw_host_model.sv */
`timescale 1ns/1ns
module tdmsw_host_model (
   input  wire logic        sys_clk,
   input  wire logic [31:0] hostRdData,
   input  wire logic        hostDone,
   input  wire logic        busErrorN,
   output logic             hostSel,
   output logic             hostWrite,
   output logic      [18:0] hostAddr,
   output logic      [3:0]  hostByteEn,
   output logic      [31:0] hostWrData
);
   // Bus idle at time zero
   initial begin
      hostSel = 1'b0;
      hostWrite = 1'b0;
      hostAddr = 19'h00000;
      hostByteEn = 4'h0;
      hostWrData = 32'h00000000;
   end

   // Hold the request until done is seen or 40 cycles pass, then release with scrambled lines
   task automatic access(input logic wr, input logic [18:0] a,
                         input logic [3:0] be, input logic [31:0] d,
                         output logic [31:0] q, output logic err,
                         output logic hung);
      int n;
      logic [31:0] dd;
      dd = d;
      if (wr && a[18:17] == 2'h0) dd[28:15] = 14'h0000;
      @(posedge sys_clk);
      hostSel <= 1'b1;
      hostWrite <= wr;
      hostAddr <= a;
      hostByteEn <= be;
      hostWrData <= dd;
      hung = 1'b1;
      for (n = 0; n < 40; n++) begin
         @(posedge sys_clk);
         if (hostDone === 1'b1) begin
            hung = 1'b0;
            break;
         end
      end
      q = hostRdData;
      err = busErrorN === 1'b0;
      hostSel <= 1'b0;
      hostWrite <= ~wr;
      hostAddr <= ~a;
      hostByteEn <= ~be;
      hostWrData <= ~dd;
   endtask : access
endmodule : tdmsw_host_model

/* verification/tb.sv */
`timescale 1ns/1ns
module tb;
   logic        sys_clk, rst, hostSel, hostWrite, hostDone, busErrorN;
   logic        inValid, slotReq, slotValid, slotOe, err;
   logic [1:0]  rateSel, inStream, outStream;
   logic [18:0] hostAddr;
   logic [3:0]  hostByteEn;
   logic [31:0] hostWrData, hostRdData, q, w;
   logic [4:0]  inGroup, outGroup;
   logic [9:0]  inSlot, outSlot;
   logic [7:0]  inByte, slotByte;
   int          errors, checked, cycles, i;
   logic [19:0] bad [5] = '{20'h03800, 20'h20200, 20'h28200, 20'h30000,
                            20'hC0290};

   tdmsw_access_map tdmsw_access_map_inst (
      .sys_clk(sys_clk), .rst(rst), .rateSel(rateSel), .hostSel(hostSel),
      .hostWrite(hostWrite), .hostAddr(hostAddr), .hostByteEn(hostByteEn),
      .hostWrData(hostWrData), .hostRdData(hostRdData),
      .hostDone(hostDone), .busErrorN(busErrorN), .inValid(inValid),
      .inGroup(inGroup), .inStream(inStream), .inSlot(inSlot),
      .inByte(inByte), .slotReq(slotReq), .outGroup(outGroup),
      .outStream(outStream), .outSlot(outSlot), .slotValid(slotValid),
      .slotOe(slotOe), .slotByte(slotByte));

   tdmsw_host_model tdmsw_host_model_inst (
      .sys_clk(sys_clk), .hostRdData(hostRdData), .hostDone(hostDone),
      .busErrorN(busErrorN), .hostSel(hostSel), .hostWrite(hostWrite),
      .hostAddr(hostAddr), .hostByteEn(hostByteEn),
      .hostWrData(hostWrData));

   task automatic end_of_test();
      if (errors == 0 && checked > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : end_of_test

   task automatic cmpWord(input logic [31:0] got, input logic [31:0] want);
      checked++;
      if (got !== want) begin
         errors++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, want);
      end
   endtask : cmpWord

   // One host access; a hung bus ends the run
   task automatic acc(input logic wr, input logic [18:0] a,
                      input logic [3:0] be, input logic [31:0] d);
      logic hung;
      tdmsw_host_model_inst.access(wr, a, be, d, q, err, hung);
      if (hung !== 1'b0) begin
         errors++;
         end_of_test();
      end
   endtask : acc

   // Store one received byte for an input slot
   task automatic capture(input logic [4:0] g, input logic [1:0] s,
                          input logic [9:0] n, input logic [7:0] b);
      @(posedge sys_clk);
      inValid <= 1'b1;
      inGroup <= g;
      inStream <= s;
      inSlot <= n;
      inByte <= b;
      @(posedge sys_clk);
      inValid <= 1'b0;
      inByte <= ~b;
   endtask : capture

   // Look up one output slot and check the answer three cycles on
   task automatic lookup(input logic [1:0] s, input logic [9:0] n,
                         input logic eo, input logic [7:0] eb);
      @(posedge sys_clk);
      slotReq <= 1'b1;
      outGroup <= 5'h04;
      outStream <= s;
      outSlot <= n;
      @(posedge sys_clk);
      slotReq <= 1'b0;
      // Answer stands for one cycle after the third edge from the take
      repeat (2) @(posedge sys_clk);
      #1;
      cmpWord({22'h0, slotValid, slotOe, slotByte},
              {22'h0, 1'b1, eo, eb});
   endtask : lookup

   // Full pass at one rate; sh is 0..3 for 65M, 32M, 16M, 8M
   // Every channel used ends in binary 11, so it sits in lane 3
   task automatic runRate(input int sh, input logic [1:0] st,
                          input logic [9:0] ch);
      logic [18:0] ca, aa, da;
      logic [31:0] src, dv;
      logic [7:0]  b [4];
      logic [7:0]  eb;
      logic [2:0]  fn;
      logic        eo;
      int k;
      rateSel <= 2'(3 - sh);
      ca = 19'h04000 + 19'(st * (32'h1000 >> sh)) + 19'({ch, 2'b00});
      aa = 19'h21000 + 19'(st * (32'h400 >> sh)) + 19'({ch[9:2], 2'b00});
      da = aa + 19'h08400;
      src = (32'(ch) << sh) | 32'(st) | 32'h00001400;
      for (k = 0; k < 4; k++) begin
         b[k] = 8'h90 + 8'(sh * 16 + k);
         capture(5'h05, st, {ch[9:2], 2'(k)}, b[k]);
      end
      acc(1'b0, da, 4'hF, 32'h0);
      cmpWord(q, {b[0], b[1], b[2], b[3]});
      acc(1'b1, da, 4'hF, 32'h0);
      cmpWord({31'h0, err}, 32'h1);
      acc(1'b0, da, 4'hF, 32'h0);
      cmpWord(q, {b[0], b[1], b[2], b[3]});
      for (k = 0; k < 8; k++) begin
         fn = 3'(k);
         w = {fn, 29'h0} | src;
         acc(1'b1, ca, 4'hF, w);
         eo = fn inside {tdmsw_pkg::FN_HIGH, tdmsw_pkg::FN_MESSAGE,
                         tdmsw_pkg::FN_VARDELAY, tdmsw_pkg::FN_CONDELAY};
         eb = fn == tdmsw_pkg::FN_HIGH ? 8'hFF :
              fn == tdmsw_pkg::FN_MESSAGE ? w[7:0] : eo ? b[3] : 8'h00;
         lookup(st, ch, eo, eb);
      end
      acc(1'b0, ca, 4'hF, 32'h0);
      cmpWord(q, w);
      // Top byte alone: the other lanes must keep their contents
      w[31:24] = 8'h20;
      acc(1'b1, ca, 4'h8, w ^ 32'h00FFFFFF);
      acc(1'b0, ca, 4'hF, 32'h0);
      cmpWord(q, w);
      dv = 32'hA1B2C3D4 ^ {4{8'(sh)}};
      acc(1'b1, aa, 4'hF, dv);
      acc(1'b0, ca, 4'hF, 32'h0);
      cmpWord(q, {w[31:8], dv[7:0]});
      acc(1'b1, aa, 4'h1, 32'h0000005A);
      acc(1'b0, aa, 4'hF, 32'h0);
      cmpWord(q, {dv[31:8], 8'h5A});
   endtask : runRate

   initial begin
      sys_clk = 1'b0;
      forever #10 sys_clk = ~sys_clk;
   end

   // Cut a hang short
   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 20000) begin
         errors++;
         end_of_test();
      end
   end

   initial begin
      rst = 1'b1;
      rateSel = tdmsw_pkg::RATE_8M;
      {inValid, slotReq, inGroup, inStream, inSlot, inByte} = '0;
      {outGroup, outStream, outSlot} = '0;
      repeat (3) @(posedge sys_clk);
      rst <= 1'b0;
      runRate(3, 2'h3, 10'd127);
      for (i = 0; i < 5; i++) begin
         acc(bad[i][19], bad[i][18:0], 4'hF, 32'h0);
         cmpWord({31'h0, err}, 32'h1);
      end
      runRate(2, 2'h3, 10'd255);
      runRate(1, 2'h1, 10'd511);
      runRate(0, 2'h0, 10'd1023);
      end_of_test();
   end
endmodule : tb
